/* File: swp_pkg.sv */
// Constants shared by the status-protection block and its range judge.
// Assumes a 100 MHz core clock and a 4 MB array in 4 KB sectors.
package swp_pkg;
	// Array geometry
	localparam int ADDR_W = 22;
	localparam int SECT_W = 10;
	localparam int NUM_LOCK = 94;
	localparam int EDGE_SECTS = 16;
	localparam int MID_BLOCKS = 62;
	localparam logic [10:0] ALL_SECTS = 11'h400;

	// Instruction codes seen on the command port
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7A;
	localparam logic [7:0] CMD_QPI_ENTER = 8'h38;
	localparam logic [7:0] CMD_QPI_EXIT = 8'hFF;
	localparam logic [7:0] CMD_OTP_KEY1 = 8'hAA;
	localparam logic [7:0] CMD_OTP_KEY2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_ERASE_4K = 8'h20;
	localparam logic [7:0] CMD_ERASE_32K = 8'h52;
	localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
	localparam logic [7:0] CMD_ERASE_CHIP = 8'hC7;

	// Field positions in the 24-bit status image
	localparam int BIT_WEL = 1;
	localparam int BIT_BP_LO = 2;
	localparam int BIT_TB = 5;
	localparam int BIT_SEC = 6;
	localparam int BIT_SRP = 7;
	localparam int BIT_SRL = 8;
	localparam int BIT_QE = 9;
	localparam int BIT_LB_LO = 11;
	localparam int BIT_CMP = 14;
	localparam int BIT_SUS = 15;
	localparam int BIT_WPS = 18;
	localparam int BIT_DRV_LO = 21;
	localparam int BIT_PINSEL = 23;

	// Reset image: drive strength 25 %, everything else clear
	localparam logic [23:0] STAT_RESET = 24'h600000;
	// Bits a status write may change; reserved and read-only bits excluded
	localparam logic [23:0] STAT_WR_MASK = 24'hE47BFC;
	localparam logic [23:0] STAT_LB_MASK = 24'h003800;

	// Drive strength codes
	localparam logic [1:0] DRV_100 = 2'h0;
	localparam logic [1:0] DRV_75 = 2'h1;
	localparam logic [1:0] DRV_50 = 2'h2;
	localparam logic [1:0] DRV_25 = 2'h3;

	// One-time-lock key tracker, Gray along the key path
	typedef enum logic [1:0] {
		KEY_IDLE = 2'h0,
		KEY_ONE = 2'h1,
		KEY_ARMED = 2'h3
	} swp_key_e;
endpackage

/* File: swp_prot_if.sv */
// Carries protection fields and the erase/program target to the judge.
// Assumes both ends sit on core_clk.
`timescale 1ns/1ps
interface swp_prot_if;
	logic cmp;
	logic sec;
	logic tb;
	logic [2:0] bp;
	logic protect_scheme_select;
	logic relock;
	logic [9:0] first_sect;
	logic [9:0] last_sect;
	logic hit;
	modport asker (output cmp, sec, tb, bp, protect_scheme_select, relock, first_sect,
		last_sect, input hit);
	modport judge (input cmp, sec, tb, bp, protect_scheme_select, relock, first_sect,
		last_sect, output hit);
endinterface

/* File: swp_prot_judge.sv */
// Decides whether an erase/program target touches protected array space.
// Assumes sector numbers of the target are supplied by the asker.
`timescale 1ns/1ps
module swp_prot_judge (
	input wire logic core_clk,
	input wire logic srst,
	swp_prot_if.judge pj
);
	logic [swp_pkg::NUM_LOCK-1:0] lock_reg;
	logic [swp_pkg::NUM_LOCK-1:0] lock_next;
	logic [swp_pkg::NUM_LOCK-1:0] unit_hit;
	logic [10:0] size;
	logic [9:0] lo;
	logic [9:0] hi;
	logic bp_hit;

	// Unlock instructions live outside this block, so locks only rearm
	always_comb begin
		lock_next = lock_reg;
	end

	// Every lock set at reset and on a power cycle
	always_ff @(posedge core_clk) begin
		if (srst || pj.relock) begin
			lock_reg <= '1;
		end else begin
			lock_reg <= lock_next;
		end
	end

	// Range size in 4 KB sectors from granularity and range code
	always_comb begin
		size = 11'h000;
		if (pj.bp == 3'h7) begin
			size = swp_pkg::ALL_SECTS;
		end else if (pj.bp != 3'h0) begin
			if (!pj.sec) begin
				size = 11'(11'h010 << (pj.bp - 3'h1));
			end else begin
				case (pj.bp)
					3'h1: size = 11'h001;
					3'h2: size = 11'h002;
					3'h3: size = 11'h004;
					default: size = 11'h008;
				endcase
			end
		end
		lo = pj.tb ? 10'h000 : 10'(swp_pkg::ALL_SECTS - size);
		hi = 10'(lo + size[9:0] - 10'h001);
		// Complement turns the chosen area into the only writable one
		if (!pj.cmp) begin
			bp_hit = (size != 11'h000) &&
				!(pj.last_sect < lo || pj.first_sect > hi);
		end else begin
			bp_hit = !((size != 11'h000) && pj.first_sect >= lo &&
				pj.last_sect <= hi);
		end
	end

	// One lock per edge sector and per middle block
	for (genvar i = 0; i < swp_pkg::NUM_LOCK; i++) begin : g_unit
		localparam int ULO = (i < swp_pkg::EDGE_SECTS) ? i :
			(i < swp_pkg::EDGE_SECTS + swp_pkg::MID_BLOCKS) ?
			swp_pkg::EDGE_SECTS * (i - swp_pkg::EDGE_SECTS + 1) :
			i + 1008 - swp_pkg::EDGE_SECTS - swp_pkg::MID_BLOCKS;
		localparam int UHI = (i < swp_pkg::EDGE_SECTS) ? i :
			(i < swp_pkg::EDGE_SECTS + swp_pkg::MID_BLOCKS) ? ULO + 15 : ULO;
		assign unit_hit[i] = lock_reg[i] &&
			!(pj.last_sect < 10'(ULO) || pj.first_sect > 10'(UHI));
	end

	// Scheme select picks block locks or the range bits
	assign pj.hit = pj.protect_scheme_select ? |unit_hit : bp_hit;
endmodule

/* File: swp_status_guard.sv */
// Status-register write protection and configuration state.
// Assumes a decoder on core_clk hands over whole instructions as pulses;
// link_clk and wp_n_pin come straight from device pins.
// What this block does
// - Keep status protect bit S7 choosing software or pin protection.
// - Lock 0, protect 0: pin ignored, write accepted when latch set and no permanent lock.
// - Lock 0, protect 1, pin low, quad enable 0: every status write rejected.
// - Lock 0, protect 1, pin high: write accepted only with latch set.
// - Status lock S8 refuses writes until power cycle, which clears it.
// - Keys AA then 55 before the lock write make it permanent.
// - Read-only suspend flag S15 set by suspend instruction 75.
// - Suspend flag cleared by resume 7A and by power cycle.
// - Three security lock bits S13..S11 start 0, never return to 0.
// - Each security lock bit settable alone by a status write.
// - Quad enable S9: 0 keeps pin functions, 1 makes pins data.
// - Enter quad mode 38 ignored while quad enable is 0.
// - In quad mode quad enable stays 1 despite status writes.
// - Scheme select 0 uses range bits, 1 uses block locks.
// - All block locks set at power-on and reset.
// - Drive field: 00 full, 01 75, 10 50, 11 25 percent, default 11.
// - Shared pin is pause when select 0, reset when select 1.
// - Quad enable 1 disables pause and reset on the shared pin.
// - Reserved bits ignore writes; host writes 0 and ignores reads.
// - Range codes map to top/bottom 64 KB or 4 KB based areas.
// - Erase or program touching any protected area is ignored.
// - Complement 1 swaps protected and unprotected areas.
// - Status write, program and erase need the latch set first.
`timescale 1ns/1ps
module swp_status_guard #(
	parameter int ADDR_W = swp_pkg::ADDR_W
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic power_cycle,
	input wire logic link_clk,
	input wire logic wp_n_pin,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [23:0] cmd_wdata,
	input wire logic [ADDR_W-1:0] cmd_first,
	input wire logic [ADDR_W-1:0] cmd_last,
	output logic [23:0] status_word,
	output logic [7:0] status_register_two,
	output logic [1:0] drive_strength,
	output logic quad_command_mode,
	output logic pin_pause_en,
	output logic pin_reset_en,
	output logic otp_locked,
	output logic status_write_done,
	output logic status_write_refused,
	output logic array_op_granted,
	output logic array_op_refused
);
	if (ADDR_W != swp_pkg::ADDR_W) begin : g_bad_width
		$error("swp_status_guard: address width must match the array");
	end

	swp_prot_if pif();
	logic [23:0] stat_reg, stat_next;
	logic qpi_reg, qpi_next;
	logic otp_reg, otp_next;
	logic pause_reg, pause_next;
	logic reset_reg, reset_next;
	logic wr_done_reg, wr_done_next;
	logic wr_ref_reg, wr_ref_next;
	logic op_ok_reg, op_ok_next;
	logic op_ref_reg, op_ref_next;
	swp_pkg::swp_key_e key_reg, key_next;
	logic lk_s1_reg, lk_s2_reg, lk_s3_reg;
	logic wp_s1_reg, wp_s2_reg;
	logic wp_hi_reg, wp_hi_next;
	logic write_enable_latch, status_protect_select, status_lock, qe, array_op, wr_allowed, go;

	swp_prot_judge u_judge (
		.core_clk(core_clk),
		.srst(srst),
		.pj(pif)
	);

	// Fields the judge needs, taken from the live image
	assign pif.cmp = stat_reg[swp_pkg::BIT_CMP];
	assign pif.sec = stat_reg[swp_pkg::BIT_SEC];
	assign pif.tb = stat_reg[swp_pkg::BIT_TB];
	assign pif.bp = stat_reg[swp_pkg::BIT_BP_LO +: 3];
	assign pif.protect_scheme_select = stat_reg[swp_pkg::BIT_WPS];
	assign pif.relock = power_cycle;
	assign pif.first_sect = cmd_first[ADDR_W-1 -: swp_pkg::SECT_W];
	assign pif.last_sect = cmd_last[ADDR_W-1 -: swp_pkg::SECT_W];

	// Pin synchronisers; wp_n_pin is read at the second stage, link_clk at the second and third
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lk_s1_reg <= 1'b0;
			lk_s2_reg <= 1'b0;
			lk_s3_reg <= 1'b0;
			wp_s1_reg <= 1'b1;
			wp_s2_reg <= 1'b1;
		end else begin
			lk_s1_reg <= link_clk;
			lk_s2_reg <= lk_s1_reg;
			lk_s3_reg <= lk_s2_reg;
			wp_s1_reg <= wp_n_pin;
			wp_s2_reg <= wp_s1_reg;
		end
	end

	// Pin level is taken at link clock rising edges, as the host sees it
	always_comb begin
		wp_hi_next = wp_hi_reg;
		if (lk_s2_reg && !lk_s3_reg) begin
			wp_hi_next = wp_s2_reg;
		end
	end

	assign write_enable_latch = stat_reg[swp_pkg::BIT_WEL];
	assign status_protect_select = stat_reg[swp_pkg::BIT_SRP];
	assign status_lock = stat_reg[swp_pkg::BIT_SRL];
	assign qe = stat_reg[swp_pkg::BIT_QE];
	assign go = cmd_valid && !power_cycle;
	assign array_op = cmd_code == swp_pkg::CMD_PROGRAM ||
		cmd_code == swp_pkg::CMD_ERASE_4K ||
		cmd_code == swp_pkg::CMD_ERASE_32K ||
		cmd_code == swp_pkg::CMD_ERASE_64K ||
		cmd_code == swp_pkg::CMD_ERASE_CHIP;
	// Pin protection only counts while the pin is not a data line
	assign wr_allowed = write_enable_latch && !otp_reg && !status_lock &&
		!(status_protect_select && !qe && !wp_hi_reg);

	// Next status image, modes and result pulses
	always_comb begin
		stat_next = stat_reg;
		qpi_next = qpi_reg;
		otp_next = otp_reg;
		key_next = key_reg;
		wr_done_next = 1'b0;
		wr_ref_next = 1'b0;
		op_ok_next = 1'b0;
		op_ref_next = 1'b0;
		if (power_cycle) begin
			stat_next[swp_pkg::BIT_SRL] = 1'b0;
			stat_next[swp_pkg::BIT_SUS] = 1'b0;
			stat_next[swp_pkg::BIT_WEL] = 1'b0;
			qpi_next = 1'b0;
			key_next = swp_pkg::KEY_IDLE;
		end else if (cmd_valid) begin
			// Keys must arrive back to back, right before the lock write
			if (cmd_code == swp_pkg::CMD_OTP_KEY1) begin
				key_next = swp_pkg::KEY_ONE;
			end else if (key_reg == swp_pkg::KEY_ONE &&
				cmd_code == swp_pkg::CMD_OTP_KEY2) begin
				key_next = swp_pkg::KEY_ARMED;
			end else begin
				key_next = swp_pkg::KEY_IDLE;
			end
			case (cmd_code)
				swp_pkg::CMD_WREN: stat_next[swp_pkg::BIT_WEL] = 1'b1;
				swp_pkg::CMD_WRDI: stat_next[swp_pkg::BIT_WEL] = 1'b0;
				swp_pkg::CMD_WRSR: begin
					stat_next[swp_pkg::BIT_WEL] = 1'b0;
					if (wr_allowed) begin
						// Reserved and read-only bits are masked off
						stat_next = (stat_reg & ~swp_pkg::STAT_WR_MASK) |
							(cmd_wdata & swp_pkg::STAT_WR_MASK);
						stat_next = stat_next |
							(stat_reg & swp_pkg::STAT_LB_MASK);
						stat_next[swp_pkg::BIT_WEL] = 1'b0;
						if (qpi_reg) begin
							stat_next[swp_pkg::BIT_QE] = 1'b1;
						end
						if (key_reg == swp_pkg::KEY_ARMED &&
							cmd_wdata[swp_pkg::BIT_SRL]) begin
							otp_next = 1'b1;
						end
						wr_done_next = 1'b1;
					end else begin
						wr_ref_next = 1'b1;
					end
				end
				swp_pkg::CMD_SUSPEND: stat_next[swp_pkg::BIT_SUS] = 1'b1;
				swp_pkg::CMD_RESUME: stat_next[swp_pkg::BIT_SUS] = 1'b0;
				swp_pkg::CMD_QPI_ENTER: begin
					if (qe) begin
						qpi_next = 1'b1;
					end
				end
				swp_pkg::CMD_QPI_EXIT: qpi_next = 1'b0;
				default: begin
					if (array_op) begin
						stat_next[swp_pkg::BIT_WEL] = 1'b0;
						if (write_enable_latch && !pif.hit) begin
							op_ok_next = 1'b1;
						end else begin
							op_ref_next = 1'b1;
						end
					end
				end
			endcase
		end
		// Shared pin role follows the committed image
		pause_next = !stat_next[swp_pkg::BIT_QE] &&
			!stat_next[swp_pkg::BIT_PINSEL];
		reset_next = !stat_next[swp_pkg::BIT_QE] &&
			stat_next[swp_pkg::BIT_PINSEL];
	end

	// Registers of the status group
	always_ff @(posedge core_clk) begin
		if (srst) begin
			stat_reg <= swp_pkg::STAT_RESET;
			qpi_reg <= 1'b0;
			otp_reg <= 1'b0;
			key_reg <= swp_pkg::KEY_IDLE;
			pause_reg <= 1'b1;
			reset_reg <= 1'b0;
			wr_done_reg <= 1'b0;
			wr_ref_reg <= 1'b0;
			op_ok_reg <= 1'b0;
			op_ref_reg <= 1'b0;
			wp_hi_reg <= 1'b1;
		end else begin
			stat_reg <= stat_next;
			qpi_reg <= qpi_next;
			otp_reg <= otp_next;
			key_reg <= key_next;
			pause_reg <= pause_next;
			reset_reg <= reset_next;
			wr_done_reg <= wr_done_next;
			wr_ref_reg <= wr_ref_next;
			op_ok_reg <= op_ok_next;
			op_ref_reg <= op_ref_next;
			wp_hi_reg <= wp_hi_next;
		end
	end

	// Outputs are flop slices; drive code goes to the pad drivers
	assign status_word = stat_reg;
	assign status_register_two = stat_reg[15:8];
	assign drive_strength = stat_reg[swp_pkg::BIT_DRV_LO +: 2];
	assign quad_command_mode = qpi_reg;
	assign pin_pause_en = pause_reg;
	assign pin_reset_en = reset_reg;
	assign otp_locked = otp_reg;
	assign status_write_done = wr_done_reg;
	assign status_write_refused = wr_ref_reg;
	assign array_op_granted = op_ok_reg;
	assign array_op_refused = op_ref_reg;

	// Checks on the status write gate, the mode bits and the array guard
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_soft_write_ok: assert property (
		go && cmd_code == swp_pkg::CMD_WRSR && write_enable_latch && !status_lock && !status_protect_select &&
		!otp_reg |=> status_write_done && !status_write_refused)
		else $error("unprotected status write was not taken");
	a_pin_low_block: assert property (
		go && cmd_code == swp_pkg::CMD_WRSR && status_protect_select && !qe && !wp_hi_reg
		|=> status_write_refused && $stable(status_word[23:2]))
		else $error("status write taken while pin protection active");
	a_latch_needed: assert property (
		go && cmd_code == swp_pkg::CMD_WRSR && !write_enable_latch
		|=> status_write_refused && !status_write_done)
		else $error("status write taken without write enable");
	a_lock_refuses: assert property (
		go && cmd_code == swp_pkg::CMD_WRSR && status_lock |=> status_write_refused)
		else $error("status write taken while locked");
	a_power_clears: assert property (
		power_cycle |=> !status_word[swp_pkg::BIT_SRL] &&
		!status_word[swp_pkg::BIT_SUS] && !quad_command_mode)
		else $error("power cycle left lock, suspend or quad mode set");
	a_otp_refuses: assert property (
		otp_locked && go && cmd_code == swp_pkg::CMD_WRSR
		|=> status_write_refused && otp_locked)
		else $error("status write taken after permanent lock");
	a_suspend_flag: assert property (
		go && cmd_code == swp_pkg::CMD_SUSPEND |=> status_word[15])
		else $error("suspend flag not set");
	a_resume_flag: assert property (
		go && cmd_code == swp_pkg::CMD_RESUME |=> !status_word[15])
		else $error("suspend flag not cleared by resume");
	a_lb_sticky: assert property (
		(status_word[13:11] & $past(status_word[13:11])) ==
		$past(status_word[13:11]))
		else $error("security lock bit returned to zero");
	a_qpi_needs_qe: assert property (
		go && cmd_code == swp_pkg::CMD_QPI_ENTER && !qe && !quad_command_mode
		|=> !quad_command_mode)
		else $error("quad mode entered with quad enable clear");
	a_qpi_keeps_qe: assert property (
		quad_command_mode |-> status_word[swp_pkg::BIT_QE])
		else $error("quad enable cleared in quad mode");
	a_pin_role: assert property (
		status_word[swp_pkg::BIT_QE] |-> !pin_pause_en && !pin_reset_en)
		else $error("pause or reset active with quad enable set");
	a_array_guard: assert property (
		go && array_op && pif.hit |=> array_op_refused && !array_op_granted)
		else $error("erase or program granted into protected space");

	c_write_done: cover property (status_write_done);
	c_otp_entered: cover property (!otp_locked ##1 otp_locked);
	c_qpi_entered: cover property (!quad_command_mode ##1 quad_command_mode);
	c_array_grant: cover property (array_op_granted);
endmodule

/* File: swp_host_model.sv */
// Host controller model that hands whole instructions to the status guard.
// Assumes drives land on core_clk falling edges; link_clk runs in frames.
`timescale 1ns/1ps
module swp_host_model (
	input wire logic core_clk,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [23:0] cmd_wdata,
	output logic [21:0] cmd_first,
	output logic [21:0] cmd_last,
	output logic link_clk,
	output logic wp_n_pin
);
	// Idle at time zero; the link clock stays parked low between frames
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 24'h000000;
		cmd_first = 22'h000000;
		cmd_last = 22'h000000;
		link_clk = 1'b0;
		wp_n_pin = 1'b1;
	end

	// One-cycle instruction; released fields are inverted so stale data
	// can never pass for a fresh request
	task automatic issue(input logic [7:0] code, input logic [23:0] wd,
		input logic [21:0] first, input logic [21:0] last);
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_wdata = wd;
		cmd_first = first;
		cmd_last = last;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		cmd_code = ~code;
		cmd_wdata = ~wd;
		cmd_first = ~first;
		cmd_last = ~last;
	endtask

	// Pin level only counts at link clock rises, so a short frame carries it
	task automatic link_frame(input logic wp);
		@(negedge core_clk);
		wp_n_pin = wp;
		#3;
		repeat (2) begin
			link_clk = 1'b1;
			#80;
			link_clk = 1'b0;
			#80;
		end
		repeat (2) @(negedge core_clk);
	endtask
endmodule

/* File: test_status_register_write_protect.sv */
// Self-checking bench for the status write protection block.
// Assumes the host model above and the guard's one-cycle answer latency.
`timescale 1ns/1ps
module test_status_register_write_protect;
	logic core_clk, srst, power_cycle;
	logic cmd_valid, link_clk, wp_n_pin;
	logic [7:0] cmd_code;
	logic [23:0] cmd_wdata;
	logic [21:0] cmd_first, cmd_last;
	logic [23:0] status_word;
	logic [7:0] status_register_two;
	logic [1:0] drive_strength;
	logic quad_command_mode, pin_pause_en, pin_reset_en, otp_locked;
	logic status_write_done, status_write_refused;
	logic array_op_granted, array_op_refused;
	logic s_done, s_ref, s_gr, s_aref, quad;
	logic [23:0] img;
	int err_total, n_tests;
	// Protection settings against erase targets; one row per case
	logic [23:0] t_wd [0:10] = '{24'h000000, 24'h00001C, 24'h000004,
		24'h000004, 24'h000004, 24'h004004, 24'h004004, 24'h000064,
		24'h000064, 24'h000024, 24'h040000};
	logic [21:0] t_lo [0:10] = '{22'h000000, 22'h100000, 22'h3F0000,
		22'h3E0000, 22'h3EF000, 22'h3E0000, 22'h3FF000, 22'h000000,
		22'h001000, 22'h00F000, 22'h100000};
	// Scheme select 1 with every lock armed refuses the last row
	logic [10:0] t_ok = 11'b00101001001;
	// Remaining array opcodes, all aimed at an unprotected array
	logic [7:0] t_cmd [0:3] = '{swp_pkg::CMD_PROGRAM,
		swp_pkg::CMD_ERASE_32K, swp_pkg::CMD_ERASE_64K,
		swp_pkg::CMD_ERASE_CHIP};

	swp_status_guard swp_status_guard_inst (.core_clk(core_clk),
		.srst(srst), .power_cycle(power_cycle), .link_clk(link_clk),
		.wp_n_pin(wp_n_pin), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_first(cmd_first), .cmd_last(cmd_last),
		.status_word(status_word), .status_register_two(status_register_two),
		.drive_strength(drive_strength),
		.quad_command_mode(quad_command_mode), .pin_pause_en(pin_pause_en),
		.pin_reset_en(pin_reset_en), .otp_locked(otp_locked),
		.status_write_done(status_write_done),
		.status_write_refused(status_write_refused),
		.array_op_granted(array_op_granted),
		.array_op_refused(array_op_refused));
	swp_host_model swp_host_model_inst (.core_clk(core_clk),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_first(cmd_first), .cmd_last(cmd_last), .link_clk(link_clk),
		.wp_n_pin(wp_n_pin));

	// Core clock, 100 MHz
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Image after an accepted write: security locks only ever gain ones
	function automatic logic [23:0] after_wr(input logic [23:0] cur,
		input logic [23:0] wd, input logic q);
		logic [23:0] r;
		r = (cur & ~swp_pkg::STAT_WR_MASK) | (wd & swp_pkg::STAT_WR_MASK);
		r = r | (cur & swp_pkg::STAT_LB_MASK);
		r[1] = 1'b0;
		if (q)
			r[9] = 1'b1;
		return r;
	endfunction

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Result pulses stand one cycle; issue returns at the low phase
	// inside that cycle, so capture them there and no later
	task automatic op(input logic [7:0] code, input logic [23:0] wd,
		input logic [21:0] first, input logic [21:0] last);
		swp_host_model_inst.issue(code, wd, first, last);
		s_done = status_write_done;
		s_ref = status_write_refused;
		s_gr = array_op_granted;
		s_aref = array_op_refused;
	endtask

	task automatic wren();
		op(swp_pkg::CMD_WREN, 24'h000000, 22'h000000, 22'h000000);
		img[1] = 1'b1;
		chk(status_word, img);
	endtask

	task automatic wrsr(input logic [23:0] wd, input logic ok);
		op(swp_pkg::CMD_WRSR, wd, 22'h000000, 22'h000000);
		chk(s_done, ok);
		chk(s_ref, !ok);
		img = ok ? after_wr(img, wd, quad) : {img[23:2], 1'b0, img[0]};
		chk(status_word, img);
		chk(status_register_two, img[15:8]);
	endtask

	task automatic erase(input logic [21:0] lo, input logic [21:0] hi,
		input logic ok);
		op(swp_pkg::CMD_ERASE_4K, 24'h000000, lo, hi);
		chk(s_gr, ok);
		chk(s_aref, !ok);
		img[1] = 1'b0;
		chk(status_word, img);
	endtask

	// Power cycle drops the volatile lock, suspend flag, latch and quad mode
	task automatic pcycle();
		@(negedge core_clk);
		power_cycle = 1'b1;
		@(negedge core_clk);
		power_cycle = 1'b0;
		@(negedge core_clk);
		img[8] = 1'b0;
		img[15] = 1'b0;
		img[1] = 1'b0;
		quad = 1'b0;
		chk(status_word, img);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Whole run is a few hundred cycles; this cuts a hang short
	initial begin
		#100000;
		err_total++;
		summarize();
	end

	// Main sequence
	initial begin
		srst = 1'b1;
		power_cycle = 1'b0;
		err_total = 0;
		n_tests = 0;
		quad = 1'b0;
		repeat (16) @(negedge core_clk);
		srst = 1'b0;
		img = swp_pkg::STAT_RESET;
		chk(status_word, img);
		chk(drive_strength, swp_pkg::DRV_25);
		chk({pin_pause_en, pin_reset_en, quad_command_mode}, 3'h4);
		wrsr(24'h000000, 1'b0);
		swp_host_model_inst.link_frame(1'b0);
		for (int i = 0; i < 11; i++) begin
			wren();
			wrsr(t_wd[i], 1'b1);
			wren();
			erase(t_lo[i], t_lo[i] + 22'h000FFF +
				((i == 4) ? 22'h001000 : 22'h000000),
				t_ok[i]);
		end
		wren();
		wrsr(24'h000000, 1'b1);
		erase(22'h000000, 22'h000FFF, 1'b0);
		// Every other array opcode is granted while nothing is protected
		for (int k = 0; k < 4; k++) begin
			wren();
			op(t_cmd[k], 24'h000000, 22'h000000, 22'h3FFFFF);
			chk({s_gr, s_aref}, 2'h2);
			img[1] = 1'b0;
			chk(status_word, img);
		end
		// Write disable drops the latch without any result pulse
		wren();
		op(swp_pkg::CMD_WRDI, 24'h000000, 22'h000000, 22'h000000);
		img[1] = 1'b0;
		chk(status_word, img);
		for (int d = 0; d < 4; d++) begin
			wren();
			wrsr(24'(d) << 21, 1'b1);
			chk(drive_strength, d[1:0]);
		end
		wren();
		wrsr(24'h800000, 1'b1);
		chk({pin_pause_en, pin_reset_en}, 2'h1);
		wren();
		wrsr(24'h800200, 1'b1);
		chk({pin_pause_en, pin_reset_en}, 2'h0);
		wren();
		wrsr(24'h000000, 1'b1);
		op(8'h38, 24'h000000, 22'h000000, 22'h000000);
		chk(quad_command_mode, 1'b0);
		wren();
		wrsr(24'h000200, 1'b1);
		op(8'h38, 24'h000000, 22'h000000, 22'h000000);
		quad = 1'b1;
		chk(quad_command_mode, 1'b1);
		wren();
		wrsr(24'h000000, 1'b1);
		op(8'hFF, 24'h000000, 22'h000000, 22'h000000);
		quad = 1'b0;
		chk(quad_command_mode, 1'b0);
		wren();
		wrsr(24'h1B0400, 1'b1);
		op(swp_pkg::CMD_SUSPEND, 24'h000000, 22'h000000, 22'h000000);
		img[15] = 1'b1;
		chk(status_word, img);
		wren();
		wrsr(24'h000000, 1'b1);
		op(swp_pkg::CMD_RESUME, 24'h000000, 22'h000000, 22'h000000);
		img[15] = 1'b0;
		chk(status_word, img);
		op(swp_pkg::CMD_SUSPEND, 24'h000000, 22'h000000, 22'h000000);
		img[15] = 1'b1;
		pcycle();
		wren();
		wrsr(24'h000800, 1'b1);
		wren();
		wrsr(24'h000000, 1'b1);
		wren();
		wrsr(24'h002000, 1'b1);
		wren();
		wrsr(24'h000080, 1'b1);
		wren();
		wrsr(24'h000000, 1'b0);
		swp_host_model_inst.link_frame(1'b1);
		wrsr(24'h000000, 1'b0);
		wren();
		wrsr(24'h000180, 1'b1);
		wren();
		wrsr(24'h000000, 1'b0);
		pcycle();
		wren();
		wrsr(24'h000000, 1'b1);
		wren();
		op(swp_pkg::CMD_OTP_KEY1, 24'h000000, 22'h000000, 22'h000000);
		op(swp_pkg::CMD_OTP_KEY2, 24'h000000, 22'h000000, 22'h000000);
		wrsr(24'h000100, 1'b1);
		chk(otp_locked, 1'b1);
		pcycle();
		wren();
		wrsr(24'h000000, 1'b0);
		summarize();
	end
endmodule
